// >>> inc/dct_map.svh
// Register map, field positions and reset values of the dual counter/timer control block.
// Assumes inclusion from the package and the logic files by bare name.
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH
// ==================================================================
// Bank selection
`define DCT_BANK_TIMER        4'hD
`define DCT_BANK_NORMAL       4'h0
// ==================================================================
// Working register addresses within the bank
`define DCT_OFS_T8CTL         4'h0
`define DCT_OFS_SHARED        4'h1
`define DCT_OFS_T16CTL        4'h2
`define DCT_OFS_SYNC          4'h3
// ==================================================================
// Timer8 control fields
`define DCT_T8_EN             7
`define DCT_T8_SINGLE         6
`define DCT_T8_TOUT           5
`define DCT_T8_CLK_HI         4
`define DCT_T8_CLK_LO         3
`define DCT_T8_CAP_MSK        2
`define DCT_T8_CNT_MSK        1
`define DCT_T8_PINSEL         0
// ==================================================================
// Shared control fields
`define DCT_SH_EDGE_HI        5
`define DCT_SH_EDGE_LO        4
`define DCT_SH_GLT_HI         3
`define DCT_SH_GLT_LO         2
`define DCT_SH_FALL_FLAG      1
`define DCT_SH_RISE_FLAG      0
`define DCT_SH_ALT_SEL        6
`define DCT_SH_PINSEL16       7
// ==================================================================
// Sync control fields and reserved read value
`define DCT_SY_T16_EN         7
`define DCT_SY_T8_EN          6
`define DCT_SY_SYNC           5
`define DCT_SY_RSVD_VAL       5'h1F
// ==================================================================
// Reset values and counts
`define DCT_RST_BYTE          8'h00
`define DCT_RELOAD8           8'hFF
`define DCT_RELOAD16          16'hFFFF
`define DCT_GLT_UNIT          4'h4
`endif

// >>> inc/dct_pkg.sv
// Types shared by the dual counter/timer control block.
// Assumes dct_map.svh is on the include path.
package dct_pkg;
   `include "dct_map.svh"
   // ==================================================================
   // Counter run state; Gray coded along idle, run, halted.
   typedef enum logic [1:0] {
      DCT_IDLE = 2'h0,
      DCT_RUN  = 2'h1,
      DCT_HALT = 2'h3
   } dct_run_t;
endpackage : dct_pkg

// >>> inc/dct_evt_if.sv
// Interface carrying edge pulses from the input filter to the control logic.
// Assumes one system clock shared by both ends.
`timescale 1ns/100ps
interface dct_evt_if;
   logic       pos_edge;   // One-cycle pulse on an accepted rising edge.
   logic       neg_edge;   // One-cycle pulse on an accepted falling edge.
   logic [1:0] edge_sel;   // Edge selection field.
   logic [1:0] glt_sel;    // Glitch width selection field.
   logic       alt_sel;    // High selects the alternate edge input.
   modport filt (output pos_edge, output neg_edge, input edge_sel, input glt_sel, input alt_sel);
   modport ctl  (input pos_edge, input neg_edge, output edge_sel, output glt_sel, output alt_sel);
endinterface : dct_evt_if

// >>> logic/dct_edge_filt.sv
// Edge detector with glitch filter for the counter/timer input pins.
// Assumes pin inputs are asynchronous; they are synchronised here.
`timescale 1ns/100ps
`include "dct_map.svh"
module dct_edge_filt
   import dct_pkg::*;
(
   input  wire logic CLK_SYS_I,
   input  wire logic RST_B_I,
   input  wire logic prim_i,
   input  wire logic alt_i,
   dct_evt_if.filt   evt
);
   // ==================================================================
   // State
   typedef struct packed {
      logic [1:0] s1;     // First synchroniser stage, read only by s2.
      logic [1:0] s2;     // Second synchroniser stage.
      logic       lvl;    // Filtered level.
      logic [5:0] cnt;    // Stability counter.
      logic       pos;
      logic       neg;
   } dct_filt_t;
   dct_filt_t q, d;
   logic       raw;
   logic [5:0] need;
   // ==================================================================
   // Filter: a new level must hold for the selected width before it is accepted.
   always_comb begin
      d      = q;
      d.s1   = {alt_i, prim_i};
      d.s2   = q.s1;
      raw    = evt.alt_sel ? q.s2[1] : q.s2[0];
      need   = {2'h0, evt.glt_sel * `DCT_GLT_UNIT};
      d.pos  = 1'b0;
      d.neg  = 1'b0;
      if (raw == q.lvl) begin
         d.cnt = 6'h00;
      end else if (q.cnt >= need) begin
         d.lvl = raw;
         d.cnt = 6'h00;
         // Rising edges report for any selection but 01, falling for any but 00.
         d.pos = raw & (evt.edge_sel != 2'h1);
         d.neg = ~raw & (evt.edge_sel != 2'h0);
      end else begin
         d.cnt = q.cnt + 6'h01;
      end
   end
   // Registers the whole state.
   always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign evt.pos_edge = q.pos;
   assign evt.neg_edge = q.neg;
endmodule : dct_edge_filt

// >>> logic/dct_clk_div.sv
// Count clock tick generator for the 8-bit counter.
// Assumes the system clock; the tick is a one-cycle pulse.
`timescale 1ns/100ps
module dct_clk_div
   import dct_pkg::*;
(
   input  wire logic       CLK_SYS_I,
   input  wire logic       RST_B_I,
   input  wire logic [1:0] sel_i,
   output logic            tick_o
);
   // ==================================================================
   // State: free-running prescaler; enabling is not phase aligned.
   typedef struct packed {
      logic [3:0] pre;
      logic       tick;
   } dct_div_t;
   dct_div_t q, d;
   // Tick rate is the system clock divided by 2, 4, 8 or 16.
   always_comb begin
      d      = q;
      d.pre  = q.pre + 4'h1;
      case (sel_i)
         2'h0:    d.tick = q.pre[0];
         2'h1:    d.tick = &q.pre[1:0];
         2'h2:    d.tick = &q.pre[2:0];
         default: d.tick = &q.pre;
      endcase
   end
   // Registers the whole state.
   always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign tick_o = q.tick;
endmodule : dct_clk_div

// >>> logic/dct_top.sv
// Control and status logic of the dual counter/timer, reached through bank D.
// Assumes a single-cycle processor register port on the system clock.
`timescale 1ns/100ps
`include "dct_map.svh"
// Functional notes
// - Writing enable one starts 8-bit counter.
// - Modulo mode reloads at terminal count.
// - Single-pass mode halts at terminal count.
// - Timeout flag sets; write one clears.
// - First count tick may be short.
// - Clock field selects count tick rate.
// - Capture mask enables capture interrupt.
// - Counter mask enables timeout interrupt.
// - Select routes latch or counter8 output.
// - Select routes latch or counter16 output.
// - Sync bits 7,6 show/start/stop counters.
// - Sync bit5 survives stop recovery; low ones.
// - Edge detector picks pin and edge.
// - Glitches narrower than selection are dropped.
// - Stop and clear act next count tick.
// - Registers at bank D, addresses 0-3.
// - Pointer nibble D swaps in expanded bank.
// - Rising captures rise reg, falling fall.
module dct_top
   import dct_pkg::*;
(
   input  wire logic       CLK_SYS_I,
   input  wire logic       RST_B_I,
   input  wire logic       SMR_I,
   input  wire logic [3:0] RP_NIBBLE_I,
   input  wire logic [3:0] REG_ADDR_I,
   input  wire logic       REG_WR_I,
   input  wire logic [7:0] REG_WDATA_I,
   output logic      [7:0] REG_RDATA_O,
   output logic            REG_HIT_O,
   input  wire logic       PORT_LATCH8_I,
   input  wire logic       PORT_LATCH16_I,
   input  wire logic       T16_OUT_I,
   input  wire logic       PRIMARY_EDGE_INPUT_I,
   input  wire logic       ALTERNATE_EDGE_INPUT_I,
   output logic            TIMER8_OUTPUT_PIN_O,
   output logic            TIMER16_OUTPUT_PIN_O,
   output logic            IRQ_O,
   output logic      [7:0] CAPTURE_RISE_REG_O,
   output logic      [7:0] CAPTURE_FALL_REG_O
);
   // ==================================================================
   // State of the block
   typedef struct packed {
      logic [7:0] t8ctl;      // Timer8 control, timeout flag included.
      logic [7:0] shared;     // Shared control, edge flags included.
      logic [7:0] t16ctl;     // Timer16 control, held for software.
      logic       t16_run;    // Running state of the 16-bit counter.
      logic       sync_en;    // Synchronised operation enable.
      dct_run_t   run8;       // Run state of the 8-bit counter.
      logic [7:0] cnt8;       // 8-bit counter value.
      logic [7:0] init8;      // Reload value of the 8-bit counter.
      logic       out8;       // Counter8 output level, toggled at timeout.
      logic       stop_pend;  // Stop waiting for the next count tick.
      logic       clr_pend;   // Timeout clear waiting for the next tick.
      logic [7:0] cap_rise;
      logic [7:0] cap_fall;
      logic [7:0] rdata;
      logic       hit;
      logic       pin8;
      logic       pin16;
      logic       irq;
   } dct_state_t;
   dct_state_t q, d;
   logic       sel;       // Access targets this bank.
   logic       tick;      // Count clock tick.
   logic       tout;      // Terminal count this cycle.
   logic       cap_evt;   // Capture happened this cycle.
   dct_evt_if  evt ();
   // ==================================================================
   // Count tick prescaler.
   dct_clk_div u_div (
      .CLK_SYS_I (CLK_SYS_I),
      .RST_B_I   (RST_B_I),
      .sel_i     (q.t8ctl[`DCT_T8_CLK_HI:`DCT_T8_CLK_LO]),
      .tick_o    (tick)
   );
   // Edge detector and glitch filter.
   dct_edge_filt u_filt (
      .CLK_SYS_I (CLK_SYS_I),
      .RST_B_I   (RST_B_I),
      .prim_i    (PRIMARY_EDGE_INPUT_I),
      .alt_i     (ALTERNATE_EDGE_INPUT_I),
      .evt       (evt.filt)
   );
   assign evt.edge_sel = q.shared[`DCT_SH_EDGE_HI:`DCT_SH_EDGE_LO];
   assign evt.glt_sel  = q.shared[`DCT_SH_GLT_HI:`DCT_SH_GLT_LO];
   assign evt.alt_sel  = q.shared[`DCT_SH_ALT_SEL];
   // ==================================================================
   // Next state: register port, counter, flags and pins.
   always_comb begin
      d       = q;
      // The bank is visible only while the pointer nibble selects bank D.
      sel     = (RP_NIBBLE_I == `DCT_BANK_TIMER) && (REG_ADDR_I <= `DCT_OFS_SYNC);
      tout    = 1'b0;
      cap_evt = 1'b0;
      d.hit   = sel;
      // Read data, registered so it appears one cycle after the address.
      case (REG_ADDR_I)
         `DCT_OFS_T8CTL:  d.rdata = q.t8ctl;
         `DCT_OFS_SHARED: d.rdata = q.shared;
         `DCT_OFS_T16CTL: d.rdata = q.t16ctl;
         `DCT_OFS_SYNC:   d.rdata = {q.t16_run, q.run8 == DCT_RUN, q.sync_en,
                                     `DCT_SY_RSVD_VAL};
         default:         d.rdata = `DCT_RST_BYTE;
      endcase
      if (!sel) begin
         d.rdata = `DCT_RST_BYTE;
      end
      // Register writes; flag bits clear only on a one, the timeout flag later, edge flags at once.
      if (sel && REG_WR_I) begin
         case (REG_ADDR_I)
            `DCT_OFS_T8CTL: begin
               d.t8ctl = {REG_WDATA_I[7:6], q.t8ctl[`DCT_T8_TOUT], REG_WDATA_I[4:0]};
               if (REG_WDATA_I[`DCT_T8_TOUT]) begin
                  d.clr_pend = 1'b1;
               end
               if (REG_WDATA_I[`DCT_T8_EN]) begin
                  // Start loads the reload value; the first tick is unaligned.
                  d.run8  = DCT_RUN;
                  d.cnt8  = q.init8;
                  d.stop_pend = 1'b0;
               end else if (q.run8 == DCT_RUN) begin
                  d.stop_pend = 1'b1;
               end
            end
            `DCT_OFS_SHARED: begin
               // Edge flags are write-one-to-clear, cleared at once.
               d.shared = {REG_WDATA_I[7:2],
                           q.shared[1] & ~REG_WDATA_I[1],
                           q.shared[0] & ~REG_WDATA_I[0]};
            end
            `DCT_OFS_T16CTL: d.t16ctl = REG_WDATA_I;
            `DCT_OFS_SYNC: begin
               d.t16_run = REG_WDATA_I[`DCT_SY_T16_EN];
               d.sync_en = REG_WDATA_I[`DCT_SY_SYNC];
               if (REG_WDATA_I[`DCT_SY_T8_EN]) begin
                  d.run8 = DCT_RUN;
                  d.cnt8 = q.init8;
                  d.stop_pend = 1'b0;
               end else if (q.run8 == DCT_RUN) begin
                  d.stop_pend = 1'b1;
               end
            end
            default: d.hit = sel;
         endcase
      end
      // Deferred stop and clear take effect on the next count tick.
      if (tick) begin
         if (q.clr_pend) begin
            d.t8ctl[`DCT_T8_TOUT] = 1'b0;
            d.clr_pend = 1'b0;
         end
         if (q.stop_pend) begin
            d.run8 = DCT_IDLE;
            d.t8ctl[`DCT_T8_EN] = 1'b0;
            d.stop_pend = 1'b0;
         end else if (q.run8 == DCT_RUN) begin
            if (q.cnt8 == `DCT_RST_BYTE) begin
               tout   = 1'b1;
               d.out8 = ~q.out8;
               if (q.t8ctl[`DCT_T8_SINGLE]) begin
                  d.run8 = DCT_HALT;
                  d.t8ctl[`DCT_T8_EN] = 1'b0;
               end else begin
                  d.cnt8 = q.init8;
               end
            end else begin
               d.cnt8 = q.cnt8 - 8'h01;
            end
         end
      end
      // Edge captures store the complemented count by edge polarity.
      if (q.run8 == DCT_RUN && evt.pos_edge) begin
         d.cap_rise = ~q.cnt8;
         d.shared[`DCT_SH_RISE_FLAG] = 1'b1;
         d.cnt8 = `DCT_RELOAD8;
         cap_evt = 1'b1;
      end
      if (q.run8 == DCT_RUN && evt.neg_edge) begin
         d.cap_fall = ~q.cnt8;
         d.shared[`DCT_SH_FALL_FLAG] = 1'b1;
         d.cnt8 = `DCT_RELOAD8;
         cap_evt = 1'b1;
      end
      // Timeout set is applied last so it wins over a pending clear.
      if (tout) begin
         d.t8ctl[`DCT_T8_TOUT] = 1'b1;
         d.clr_pend = 1'b0;
      end
      // Interrupt request follows the masks.
      d.irq   = (cap_evt & q.t8ctl[`DCT_T8_CAP_MSK]) |
                (tout & q.t8ctl[`DCT_T8_CNT_MSK]);
      d.pin8  = q.t8ctl[`DCT_T8_PINSEL] ? q.out8 : PORT_LATCH8_I;
      d.pin16 = q.shared[`DCT_SH_PINSEL16] ? T16_OUT_I : PORT_LATCH16_I;
      // Stop-mode recovery clears everything except the sync enable; the reload value returns to all ones.
      if (SMR_I) begin
         d         = '0;
         d.sync_en = q.sync_en;
         d.init8   = `DCT_RELOAD8;
      end
   end
   // ==================================================================
   // Registers the whole state; the reload value defaults to all ones.
   always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         q       <= '0;
         q.init8 <= `DCT_RELOAD8;
      end else begin
         q <= d;
      end
   end
   assign REG_RDATA_O          = q.rdata;
   assign REG_HIT_O            = q.hit;
   assign TIMER8_OUTPUT_PIN_O  = q.pin8;
   assign TIMER16_OUTPUT_PIN_O = q.pin16;
   assign IRQ_O                = q.irq;
   assign CAPTURE_RISE_REG_O   = q.cap_rise;
   assign CAPTURE_FALL_REG_O   = q.cap_fall;
endmodule : dct_top

// >>> dv/dct_top_chk.sv
// Port checker of the counter/timer control block.
// Assumes it is bound onto dct_top and that the block has one clock domain.
`timescale 1ns/100ps
module dct_top_chk
   import dct_pkg::*;
(
   input wire logic       CLK_SYS_I,
   input wire logic       RST_B_I,
   input wire logic       SMR_I,
   input wire logic [3:0] RP_NIBBLE_I,
   input wire logic [3:0] REG_ADDR_I,
   input wire logic       REG_WR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic [7:0] REG_RDATA_O,
   input wire logic       REG_HIT_O,
   input wire logic       PORT_LATCH8_I,
   input wire logic       PORT_LATCH16_I,
   input wire logic       T16_OUT_I,
   input wire logic       TIMER8_OUTPUT_PIN_O,
   input wire logic       TIMER16_OUTPUT_PIN_O,
   input wire logic       IRQ_O
);
   // ==================================================================
   // Helper state
   logic up_q;     // High from the first edge after reset.
   logic sel8_q;   // Shadow of the timer8 pin select.
   logic sel16_q;  // Shadow of the timer16 pin select.
   wire logic tk = REG_WR_I && RP_NIBBLE_I == 4'hD && REG_ADDR_I < 4'h4;
   // Shadows follow accepted writes; recovery clears them like the block does.
   always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         up_q    <= 1'b0;
         sel8_q  <= 1'b0;
         sel16_q <= 1'b0;
      end else begin
         up_q <= 1'b1;
         if (SMR_I) begin
            sel8_q  <= 1'b0;
            sel16_q <= 1'b0;
         end else if (tk && REG_ADDR_I == 4'h0) begin
            sel8_q <= REG_WDATA_I[0];
         end else if (tk && REG_ADDR_I == 4'h1) begin
            sel16_q <= REG_WDATA_I[7];
         end
      end
   end
   // ==================================================================
   // Assertions
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_B_I);
   a_hit_bank_d: assert property (up_q && !$past(SMR_I) |-> REG_HIT_O ==
      ($past(RP_NIBBLE_I) == 4'hD && $past(REG_ADDR_I) < 4'h4)) else $error("hit flag wrong");
   a_miss_reads_zero: assert property (!REG_HIT_O |-> REG_RDATA_O == 8'h00)
      else $error("unselected read not zero");
   a_sync_low_ones: assert property (REG_HIT_O && $past(REG_ADDR_I) == 4'h3
      |-> REG_RDATA_O[4:0] == 5'h1F) else $error("sync low bits wrong");
   a_sync_bit_store: assert property (tk && REG_ADDR_I == 4'h3 ##1
      (!REG_WR_I && RP_NIBBLE_I == 4'hD && REG_ADDR_I == 4'h3)
      |=> REG_RDATA_O[5] == $past(REG_WDATA_I[5], 2)) else $error("sync bit not stored");
   a_t8_cfg_store: assert property (tk && REG_ADDR_I == 4'h0 && !SMR_I ##1
      (!REG_WR_I && !SMR_I && RP_NIBBLE_I == 4'hD && REG_ADDR_I == 4'h0)
      |=> REG_RDATA_O[4:0] == $past(REG_WDATA_I[4:0], 2)) else $error("t8 config lost");
   a_pin16_route: assert property (up_q && !$past(SMR_I) |-> TIMER16_OUTPUT_PIN_O ==
      ($past(sel16_q) ? $past(T16_OUT_I) : $past(PORT_LATCH16_I))) else $error("pin16 wrong");
   a_pin8_latch: assert property (up_q && !$past(SMR_I) && !$past(sel8_q)
      |-> TIMER8_OUTPUT_PIN_O == $past(PORT_LATCH8_I)) else $error("pin8 not latch");
   a_irq_one_pulse: assert property (IRQ_O |=> !IRQ_O)
      else $error("irq longer than one cycle");
endmodule : dct_top_chk

bind dct_top dct_top_chk i_chk (.CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I), .SMR_I(SMR_I),
   .RP_NIBBLE_I(RP_NIBBLE_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_HIT_O(REG_HIT_O),
   .PORT_LATCH8_I(PORT_LATCH8_I), .PORT_LATCH16_I(PORT_LATCH16_I), .T16_OUT_I(T16_OUT_I),
   .TIMER8_OUTPUT_PIN_O(TIMER8_OUTPUT_PIN_O), .TIMER16_OUTPUT_PIN_O(TIMER16_OUTPUT_PIN_O),
   .IRQ_O(IRQ_O));

// >>> dv/dct_pin_model.sv
// Far-side model: pulse source on the two edge input pins.
// Assumes the bench starts each pulse with a one-cycle go request.
`timescale 1ns/100ps
module dct_pin_model (
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic       use_alt_i,
   input  wire logic [7:0] width_i,
   output logic            prim_o,
   output logic            alt_o
);
   logic [7:0] left_q = 8'h00;  // Cycles of the pulse still to run.
   logic       alt_q  = 1'b0;   // Pin that carries the pulse.
   // ==================================================================
   // Pulse timing; narrow widths exercise the glitch filter.
   always @(posedge clk_i) begin
      if (go_i) begin
         left_q <= width_i;
         alt_q  <= use_alt_i;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end
   // Both pins idle low between pulses.
   assign prim_o = (left_q != 8'h00) && !alt_q;
   assign alt_o  = (left_q != 8'h00) && alt_q;
endmodule : dct_pin_model

// >>> dv/dual_counter_timer_control_bench.sv
// Self-checking bench of the dual counter/timer control block.
// Assumes dct_top, its bound checker and the pin model are compiled first.
`timescale 1ns/100ps
module dual_counter_timer_control_bench import dct_pkg::*;;
   logic       clk = 1'b0, rst_b = 1'b0, smr = 1'b0, wr = 1'b0, go = 1'b0, pa = 1'b0;
   logic       l8 = 1'b0, l16 = 1'b0, t16o = 1'b0, hit, p8, p16, irq, prim, alt;
   logic [3:0] rp = 4'h0, adr = 4'h0;
   logic [7:0] wd = 8'h00, pw = 8'h00, rdat, cr, cf, d;
   logic [31:0] r;
   int         errors = 0, compares = 0, cyc = 0, irqs = 0, s, n0, n1;
   // Rows: shared config, pin select, pulse width, expected edge flags.
   logic [23:0] et [6] = '{24'h03_0_0A_1, 24'h03_1_0A_0, 24'h53_1_0A_2,
                           24'h23_0_0A_3, 24'h0F_0_04_0, 24'h0F_0_1E_1};
   dct_top i_dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .SMR_I(smr), .RP_NIBBLE_I(rp),
      .REG_ADDR_I(adr), .REG_WR_I(wr), .REG_WDATA_I(wd), .REG_RDATA_O(rdat),
      .REG_HIT_O(hit), .PORT_LATCH8_I(l8), .PORT_LATCH16_I(l16), .T16_OUT_I(t16o),
      .PRIMARY_EDGE_INPUT_I(prim), .ALTERNATE_EDGE_INPUT_I(alt),
      .TIMER8_OUTPUT_PIN_O(p8), .TIMER16_OUTPUT_PIN_O(p16), .IRQ_O(irq),
      .CAPTURE_RISE_REG_O(cr), .CAPTURE_FALL_REG_O(cf));
   dct_pin_model i_pins (.clk_i(clk), .go_i(go), .use_alt_i(pa), .width_i(pw),
      .prim_o(prim), .alt_o(alt));
   // ==================================================================
   // Clock, interrupt tally and hang guard
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (irq === 1'b1) irqs <= irqs + 1;
      if (cyc == 40000) begin
         errors++;
         complete_run();
      end
   end
   // ==================================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wrr(input logic [3:0] b, input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      rp  <= b;
      adr <= a;
      wd  <= v;
      wr  <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wrr
   // Read data is registered, so it is taken one edge after the address.
   task automatic rd(input logic [3:0] b, input logic [3:0] a);
      @(posedge clk);
      rp  <= b;
      adr <= a;
      @(posedge clk);
      #1;
      d = rdat;
   endtask : rd
   task automatic pulse(input logic a, input logic [7:0] w);
      @(posedge clk);
      go <= 1'b1;
      pa <= a;
      pw <= w;
      @(posedge clk);
      go <= 1'b0;
   endtask : pulse
   // Counts edges until the next interrupt; bounded so a dead counter is caught.
   task automatic wait_irq(output int n);
      int st;
      st = irqs;
      n  = 0;
      while (irqs == st && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk("irq seen", 16'(irqs != st), 16'h0001);
   endtask : wait_irq
   function automatic logic [7:0] sync_exp(input logic t16, input logic t8, input logic sy);
      return {t16, t8, sy, 5'h1F};
   endfunction : sync_exp
   task automatic complete_run();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   // ==================================================================
   // Main sequence
   initial begin
      void'($urandom(32'hBB6B));
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rd(4'hD, 4'h0);
      chk("t8ctl reset", {8'h00, d}, 16'h0000);
      rd(4'hD, 4'h3);
      chk("sync reset", {8'h00, d}, {8'h00, sync_exp(1'b0, 1'b0, 1'b0)});
      rd(4'h0, 4'h3);
      chk("normal bank", {7'h00, hit, d}, 16'h0000);
      rd(4'hD, 4'h5);
      chk("unmapped", {7'h00, hit, d}, 16'h0000);
      $display("test decode done");
      repeat (4) begin
         r = $urandom;
         wrr(4'hD, 4'h2, r[7:0]);
         wrr(4'h0, 4'h2, ~r[7:0]);
         rd(4'hD, 4'h2);
         chk("t16 store", {8'h00, d}, {8'h00, r[7:0]});
      end
      wrr(4'hD, 4'h3, 8'h40);
      rd(4'hD, 4'h3);
      chk("sync start", {8'h00, d}, {8'h00, sync_exp(1'b0, 1'b1, 1'b0)});
      wrr(4'hD, 4'h3, 8'h20);
      repeat (8) @(posedge clk);
      rd(4'hD, 4'h3);
      chk("sync stop", {8'h00, d}, {8'h00, sync_exp(1'b0, 1'b0, 1'b1)});
      @(posedge clk);
      smr <= 1'b1;
      @(posedge clk);
      smr <= 1'b0;
      rd(4'hD, 4'h3);
      chk("sync survives", {8'h00, d}, {8'h00, sync_exp(1'b0, 1'b0, 1'b1)});
      rd(4'hD, 4'h2);
      chk("recovery clears", {8'h00, d}, 16'h0000);
      wrr(4'hD, 4'h3, 8'h00);
      $display("test sync done");
      // Stale timeout is cleared before the counter is enabled.
      wrr(4'hD, 4'h0, 8'h20);
      wrr(4'hD, 4'h0, 8'hC2);
      wait_irq(n0);
      rd(4'hD, 4'h0);
      chk("timeout set", {15'h0000, d[5]}, 16'h0001);
      rd(4'hD, 4'h3);
      chk("single halts", {15'h0000, d[6]}, 16'h0000);
      // Stop with the flag bit written zero, then clear in a later write.
      wrr(4'hD, 4'h0, 8'h42);
      rd(4'hD, 4'h0);
      chk("zero keeps flag", {15'h0000, d[5]}, 16'h0001);
      wrr(4'hD, 4'h0, 8'h20);
      repeat (8) @(posedge clk);
      rd(4'hD, 4'h0);
      chk("one clears flag", {15'h0000, d[5]}, 16'h0000);
      $display("test single done");
      // The first interval after a rate change may be short, so it is skipped.
      wrr(4'hD, 4'h0, 8'h82);
      wait_irq(n0);
      wait_irq(n0);
      wrr(4'hD, 4'h0, 8'h8A);
      wait_irq(n1);
      wait_irq(n1);
      chk("rate ratio", 16'(n1), 16'(2 * n0));
      rd(4'hD, 4'h3);
      chk("modulo runs", {15'h0000, d[6]}, 16'h0001);
      wrr(4'hD, 4'h3, 8'h00);
      repeat (8) @(posedge clk);
      rd(4'hD, 4'h3);
      chk("stopped", {15'h0000, d[6]}, 16'h0000);
      wrr(4'hD, 4'h0, 8'h20);
      $display("test modulo done");
      wrr(4'hD, 4'h0, 8'h84);
      foreach (et[i]) begin
         s = irqs;
         wrr(4'hD, 4'h1, et[i][23:16]);
         pulse(et[i][12], et[i][11:4]);
         repeat (60) @(posedge clk);
         rd(4'hD, 4'h1);
         chk("edge flags", {8'h00, d}, {8'h00, et[i][23:18], et[i][1:0]});
         chk("capture irq", 16'(irqs != s), 16'(et[i][1:0] != 2'b00));
      end
      // The both-edges row reloads on the rise and captures ten cycles later.
      chk("fall capture", 16'(cf >= 8'h04 && cf <= 8'h05), 16'h0001);
      $display("test edges done");
      repeat (8) begin
         r = $urandom;
         @(posedge clk);
         l8   <= r[0];
         l16  <= r[1];
         t16o <= r[2];
         wrr(4'hD, 4'h1, {r[3], 7'h00});
         repeat (2) @(posedge clk);
         #1;
         chk("pin16", {15'h0000, p16}, {15'h0000, r[3] ? r[2] : r[1]});
         chk("pin8", {15'h0000, p8}, {15'h0000, r[0]});
      end
      $display("test pins done");
      complete_run();
   end
endmodule : dual_counter_timer_control_bench
